// File: include/mpscfg_pkg.sv
package mpscfg_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] MPSCFG_OFS_FIXED_ONES  = 8'h39;
  localparam logic [7:0] MPSCFG_OFS_BIAS_BOOST  = 8'h3A;
  localparam logic [7:0] MPSCFG_OFS_CLK_SYSREF  = 8'h53;
  localparam logic [7:0] MPSCFG_OFS_SOFT_SYSREF = 8'h54;
  localparam logic [7:0] MPSCFG_OFS_PDN         = 8'h55;
  localparam logic [7:0] MPSCFG_OFS_BIAS_EN     = 8'h56;
  localparam logic [7:0] MPSCFG_OFS_PDN_SEL     = 8'h26;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MPSCFG_BIT_CLK_DIV      = 7;
  localparam int MPSCFG_BIT_SYSREF_IGN   = 6;
  localparam int MPSCFG_BIT_SYSREF_LVL   = 0;
  localparam int MPSCFG_BIT_SOFT_EN      = 7;
  localparam int MPSCFG_BIT_PDN_REQ      = 4;
  localparam int MPSCFG_BIT_PDN_SEL      = 5;
  localparam int MPSCFG_BIT_BOOST        = 6;
  localparam int MPSCFG_BIT_BOOST_EN     = 3;
  localparam int MPSCFG_BIT_FIXED_HI     = 7;
  localparam int MPSCFG_BIT_FIXED_LO     = 6;

  // Implemented bits per register; all others are reserved
  localparam logic [7:0] MPSCFG_MSK_FIXED_ONES  = 8'hC0;
  localparam logic [7:0] MPSCFG_MSK_BIAS_BOOST  = 8'h40;
  localparam logic [7:0] MPSCFG_MSK_CLK_SYSREF  = 8'hC1;
  localparam logic [7:0] MPSCFG_MSK_SOFT_SYSREF = 8'h80;
  localparam logic [7:0] MPSCFG_MSK_PDN         = 8'h10;
  localparam logic [7:0] MPSCFG_MSK_BIAS_EN     = 8'h08;
  localparam logic [7:0] MPSCFG_MSK_PDN_SEL     = 8'h20;

  // ----------------------------------------------------------------
  // Reset value of every register
  // ----------------------------------------------------------------
  localparam logic [7:0] MPSCFG_RST_VAL = 8'h00;

endpackage : mpscfg_pkg

// File: hdl/mpscfg_regs.sv
`timescale 1ns/1ps
// Overview of operation
// R01 - Clock divider bit: 0 divide-4, 1 divide-2
// R02 - Host must program divide-by-two setting
// R03 - sysref_ignore set blocks external SYSREF input
// R04 - sysref_soft_level drives internal SYSREF level
// R05 - sysref_soft_enable hands SYSREF to register path
// R06 - Power-down request gates selected mask blocks
// R07 - Bias boost bit raises buffer current
// R08 - Boost enable bit must accompany boost
// R09 - Host writes ones into fixed field
// R10 - Select bit picks mask one or two
// R11 - Reserved bits ignored, read back zero
// R12 - All registers clear to zero on reset
module mpscfg_regs
  import mpscfg_pkg::*;
#(
  parameter int MASK_W = 12
) (
  clk,
  rst,
  wr_en,
  rd_en,
  addr,
  wdata,
  rdata,
  rd_hit,
  sysref_pin,
  masked_powerdown_request_a,
  masked_powerdown_request_b,
  clk_div_by_two,
  sysref_int,
  pdn_blocks,
  bias_boost_on,
  fixed_ones_ok
);
  input  wire logic              clk;
  input  wire logic              rst;
  input  wire logic              wr_en;
  input  wire logic              rd_en;
  input  wire logic [7:0]        addr;
  input  wire logic [7:0]        wdata;
  output logic      [7:0]        rdata;
  output logic                   rd_hit;
  input  wire logic              sysref_pin;
  input  wire logic [MASK_W-1:0] masked_powerdown_request_a;
  input  wire logic [MASK_W-1:0] masked_powerdown_request_b;
  output logic                   clk_div_by_two;
  output logic                   sysref_int;
  output logic      [MASK_W-1:0] pdn_blocks;
  output logic                   bias_boost_on;
  output logic                   fixed_ones_ok;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (MASK_W < 1 || MASK_W > 64) begin : g_bad_mask_w
    $error("MASK_W must lie between 1 and 64");
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] fixed_reg,  fixed_next;
  logic [7:0] boost_reg,  boost_next;
  logic [7:0] clksr_reg,  clksr_next;
  logic [7:0] softsr_reg, softsr_next;
  logic [7:0] pdn_reg,    pdn_next;
  logic [7:0] boosten_reg, boosten_next;
  logic [7:0] pdnsel_reg, pdnsel_next;
  logic [7:0] rdata_reg,  rdata_next;
  logic       hit_reg,    hit_next;

  // Write decode; reserved positions masked so they never store
  always_comb begin
    fixed_next   = fixed_reg;
    boost_next   = boost_reg;
    clksr_next   = clksr_reg;
    softsr_next  = softsr_reg;
    pdn_next     = pdn_reg;
    boosten_next = boosten_reg;
    pdnsel_next  = pdnsel_reg;
    if (wr_en) begin
      if (addr == MPSCFG_OFS_FIXED_ONES) begin
        fixed_next = wdata & MPSCFG_MSK_FIXED_ONES; // see R09 see R11
      end else if (addr == MPSCFG_OFS_BIAS_BOOST) begin
        boost_next = wdata & MPSCFG_MSK_BIAS_BOOST; // see R11
      end else if (addr == MPSCFG_OFS_CLK_SYSREF) begin
        clksr_next = wdata & MPSCFG_MSK_CLK_SYSREF; // see R11
      end else if (addr == MPSCFG_OFS_SOFT_SYSREF) begin
        softsr_next = wdata & MPSCFG_MSK_SOFT_SYSREF;
      end else if (addr == MPSCFG_OFS_PDN) begin
        pdn_next = wdata & MPSCFG_MSK_PDN;
      end else if (addr == MPSCFG_OFS_BIAS_EN) begin
        boosten_next = wdata & MPSCFG_MSK_BIAS_EN;
      end else if (addr == MPSCFG_OFS_PDN_SEL) begin
        pdnsel_next = wdata & MPSCFG_MSK_PDN_SEL;
      end
    end
  end

  // Read mux; unmapped offsets return zero with no hit
  always_comb begin
    rdata_next = 8'h00;
    hit_next   = 1'b0;
    if (rd_en) begin
      hit_next = 1'b1;
      if (addr == MPSCFG_OFS_FIXED_ONES) begin
        rdata_next = fixed_reg;
      end else if (addr == MPSCFG_OFS_BIAS_BOOST) begin
        rdata_next = boost_reg;
      end else if (addr == MPSCFG_OFS_CLK_SYSREF) begin
        rdata_next = clksr_reg;
      end else if (addr == MPSCFG_OFS_SOFT_SYSREF) begin
        rdata_next = softsr_reg;
      end else if (addr == MPSCFG_OFS_PDN) begin
        rdata_next = pdn_reg;
      end else if (addr == MPSCFG_OFS_BIAS_EN) begin
        rdata_next = boosten_reg;
      end else if (addr == MPSCFG_OFS_PDN_SEL) begin
        rdata_next = pdnsel_reg;
      end else begin
        hit_next = 1'b0;
      end
    end
  end

  // All storage clears to zero, giving divide-by-four and normal operation
  always_ff @(posedge clk) begin
    if (rst) begin
      fixed_reg   <= MPSCFG_RST_VAL; // see R12
      boost_reg   <= MPSCFG_RST_VAL;
      clksr_reg   <= MPSCFG_RST_VAL;
      softsr_reg  <= MPSCFG_RST_VAL;
      pdn_reg     <= MPSCFG_RST_VAL;
      boosten_reg <= MPSCFG_RST_VAL;
      pdnsel_reg  <= MPSCFG_RST_VAL;
      rdata_reg   <= MPSCFG_RST_VAL;
      hit_reg     <= 1'b0;
    end else begin
      fixed_reg   <= fixed_next;
      boost_reg   <= boost_next;
      clksr_reg   <= clksr_next;
      softsr_reg  <= softsr_next;
      pdn_reg     <= pdn_next;
      boosten_reg <= boosten_next;
      pdnsel_reg  <= pdnsel_next;
      rdata_reg   <= rdata_next;
      hit_reg     <= hit_next;
    end
  end

  assign rdata  = rdata_reg;
  assign rd_hit = hit_reg;

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  logic [MASK_W-1:0] mask_sel;
  logic              sysref_pin_path;

  // Divider setting straight from its bit; host is expected to pick two
  assign clk_div_by_two = clksr_reg[MPSCFG_BIT_CLK_DIV]; // see R01 see R02

  // Ignore only gates the pin path, never the soft level
  assign sysref_pin_path = sysref_pin & ~clksr_reg[MPSCFG_BIT_SYSREF_IGN]; // see R03
  assign sysref_int = softsr_reg[MPSCFG_BIT_SOFT_EN] ? clksr_reg[MPSCFG_BIT_SYSREF_LVL] // see R04 see R05
                                                      : sysref_pin_path;

  // Mask select then request gate
  assign mask_sel   = pdnsel_reg[MPSCFG_BIT_PDN_SEL] ? masked_powerdown_request_b : masked_powerdown_request_a; // see R10
  assign pdn_blocks = pdn_reg[MPSCFG_BIT_PDN_REQ] ? mask_sel : '0; // see R06

  // Boost needs both bits; either alone leaves normal bias
  assign bias_boost_on = boost_reg[MPSCFG_BIT_BOOST] & boosten_reg[MPSCFG_BIT_BOOST_EN]; // see R07 see R08

  // Status flag so software misprogramming of the fixed field is visible
  assign fixed_ones_ok = fixed_reg[MPSCFG_BIT_FIXED_HI] & fixed_reg[MPSCFG_BIT_FIXED_LO];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_wr_clk(logic v);
    wr_en && addr == MPSCFG_OFS_CLK_SYSREF && wdata[MPSCFG_BIT_CLK_DIV] == v;
  endsequence

  property p_clk_div;
    @(posedge clk) disable iff (rst) s_wr_clk(1'b1) |=> clk_div_by_two;
  endproperty
  a_clk_div: assert property (p_clk_div) else $error("divider bit not set"); // see R01

  property p_ignore;
    @(posedge clk) disable iff (rst)
      (clksr_reg[MPSCFG_BIT_SYSREF_IGN] && !softsr_reg[MPSCFG_BIT_SOFT_EN]) |-> !sysref_int;
  endproperty
  a_ignore: assert property (p_ignore) else $error("sysref pin not ignored"); // see R03

  // Level write while the register path owns SYSREF
  sequence s_wr_lvl(logic v);
    wr_en && addr == MPSCFG_OFS_CLK_SYSREF && wdata[MPSCFG_BIT_SYSREF_LVL] == v;
  endsequence

  property p_soft_level;
    @(posedge clk) disable iff (rst)
      (s_wr_lvl(1'b1) ##0 softsr_reg[MPSCFG_BIT_SOFT_EN]) |=> sysref_int;
  endproperty
  a_soft_level: assert property (p_soft_level) else $error("soft sysref level wrong"); // see R04

  property p_soft_handover;
    @(posedge clk) disable iff (rst)
      (wr_en && addr == MPSCFG_OFS_SOFT_SYSREF && wdata[MPSCFG_BIT_SOFT_EN])
        ##1 (!wr_en)[*2] |-> sysref_int == clksr_reg[MPSCFG_BIT_SYSREF_LVL];
  endproperty
  a_soft_handover: assert property (p_soft_handover) else $error("soft sysref not in control"); // see R05

  property p_pdn;
    @(posedge clk) disable iff (rst)
      !pdn_reg[MPSCFG_BIT_PDN_REQ] |-> pdn_blocks == '0;
  endproperty
  a_pdn: assert property (p_pdn) else $error("blocks powered down without request"); // see R06

  property p_pdn_sel;
    @(posedge clk) disable iff (rst)
      (pdn_reg[MPSCFG_BIT_PDN_REQ] && pdnsel_reg[MPSCFG_BIT_PDN_SEL]) |-> pdn_blocks == masked_powerdown_request_b;
  endproperty
  a_pdn_sel: assert property (p_pdn_sel) else $error("wrong power-down mask used"); // see R10

  // Enable written while the boost bit already stands
  sequence s_boost_armed;
    wr_en && addr == MPSCFG_OFS_BIAS_EN && wdata[MPSCFG_BIT_BOOST_EN] && boost_reg[MPSCFG_BIT_BOOST];
  endsequence

  property p_boost;
    @(posedge clk) disable iff (rst)
      s_boost_armed |=> bias_boost_on;
  endproperty
  a_boost: assert property (p_boost) else $error("boost not applied with both bits"); // see R07 see R08

  property p_reserved;
    @(posedge clk) disable iff (rst)
      (rd_en && addr == MPSCFG_OFS_BIAS_BOOST) |=> (rdata & ~MPSCFG_MSK_BIAS_BOOST) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero"); // see R11

  property p_reset;
    @(posedge clk) rst |=> clksr_reg == 8'h00 && pdn_reg == 8'h00 && rdata == 8'h00;
  endproperty
  a_reset: assert property (p_reset) else $error("register not cleared by reset"); // see R12

endmodule : mpscfg_regs

// File: verif/mpscfg_host.sv
`timescale 1ns/1ps
module mpscfg_host
  import mpscfg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  input  wire logic       rd_hit,
  output logic            wr_en,
  output logic            rd_en,
  output logic      [7:0] addr,
  output logic      [7:0] wdata
);
  // ----------------------------------------
  // Host side of the register port
  // ----------------------------------------
  // Idle bus at time zero
  initial begin
    wr_en = 1'h0;
    rd_en = 1'h0;
    addr  = 8'h00;
    wdata = 8'h00;
  end

  // Released bus shows inverted data so stale values never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr  = a;
    wdata = d;
    wr_en = 1'h1;
    @(negedge clk);
    wr_en = 1'h0;
    addr  = ~a;
    wdata = ~d;
  endtask : wr

  // Read data is registered, so it is taken one edge later
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(negedge clk);
    addr  = a;
    rd_en = 1'h1;
    @(negedge clk);
    rd_en = 1'h0;
    addr  = ~a;
    d     = rdata;
    h     = rd_hit;
  endtask : rd

  // Mandatory bring-up writes
  task automatic init();
    wr(MPSCFG_OFS_CLK_SYSREF, 8'h80);
    wr(MPSCFG_OFS_FIXED_ONES, 8'hC0);
  endtask : init
endmodule : mpscfg_host

// File: verif/mpscfg_regs_bench.sv
`timescale 1ns/1ps
module mpscfg_regs_bench;
  import mpscfg_pkg::*;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        sysref_pin = 1'h0;
  logic [11:0] mask_a = 12'hA5A;
  logic [11:0] mask_b = 12'h5C3;
  logic        wr_en, rd_en, rd_hit, div2, sref, boost, ones_ok, h;
  logic [7:0]  addr, wdata, rdata, d;
  logic [11:0] pdn_blocks;
  int          error_cnt = 0;
  int          checked = 0;
  logic [7:0]  ofs [7] = '{MPSCFG_OFS_FIXED_ONES, MPSCFG_OFS_BIAS_BOOST, MPSCFG_OFS_CLK_SYSREF,
                           MPSCFG_OFS_SOFT_SYSREF, MPSCFG_OFS_PDN, MPSCFG_OFS_BIAS_EN, MPSCFG_OFS_PDN_SEL};

  // ----------------------------------------
  // Clock, design and host
  // ----------------------------------------
  always #12.5 clk = ~clk;

  mpscfg_regs #(.MASK_W(12)) mpscfg_regs_i (.clk(clk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata), .rdata(rdata), .rd_hit(rd_hit), .sysref_pin(sysref_pin), .masked_powerdown_request_a(mask_a),
    .masked_powerdown_request_b(mask_b), .clk_div_by_two(div2), .sysref_int(sref), .pdn_blocks(pdn_blocks),
    .bias_boost_on(boost), .fixed_ones_ok(ones_ok));

  mpscfg_host mpscfg_host_i (.clk(clk), .rdata(rdata), .rd_hit(rd_hit), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wdata(wdata));

  // ----------------------------------------
  // Checking helpers and scenarios
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  // Read back one register, expecting a mapped hit
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    mpscfg_host_i.rd(a, d, h);
    chk("rdata", d, exp);
    chk("rd_hit", h, 16'h1);
  endtask : rchk

  // Reset held two cycles, then every register and the div, ones_ok, boost and pdn outputs are idle
  task automatic t_reset();
    rst = 1'h1;
    repeat (2) @(negedge clk);
    rst = 1'h0;
    chk("div", div2, 16'h0);
    chk("ones_ok", ones_ok, 16'h0);
    chk("boost", boost, 16'h0);
    chk("pdn", pdn_blocks, 16'h0);
    for (int i = 0; i < 7; i++) rchk(ofs[i], 8'h00);
  endtask : t_reset

  // Fixed field, and an unmapped read that must miss
  task automatic t_fixed();
    chk("ones_ok", ones_ok, 16'h1);
    rchk(MPSCFG_OFS_FIXED_ONES, 8'hC0);
    mpscfg_host_i.rd(8'h40, d, h);
    chk("unmapped", {h, d}, 16'h0);
  endtask : t_fixed

  // Pin masking, then soft enable before soft level
  task automatic t_sysref();
    sysref_pin = 1'h1;
    mpscfg_host_i.wr(MPSCFG_OFS_CLK_SYSREF, 8'hFE);
    chk("div", div2, 16'h1);
    chk("sref_ign", sref, 16'h0);
    rchk(MPSCFG_OFS_CLK_SYSREF, 8'hC0);
    // Soft control is enabled before any level is applied
    mpscfg_host_i.wr(MPSCFG_OFS_SOFT_SYSREF, 8'h80);
    mpscfg_host_i.wr(MPSCFG_OFS_CLK_SYSREF, 8'h81);
    sysref_pin = 1'h0;
    #1 chk("sref_soft1", sref, 16'h1);
    mpscfg_host_i.wr(MPSCFG_OFS_CLK_SYSREF, 8'h80);
    sysref_pin = 1'h1;
    #1 chk("sref_soft0", sref, 16'h0);
    mpscfg_host_i.wr(MPSCFG_OFS_SOFT_SYSREF, 8'h00);
    chk("sref_pin1", sref, 16'h1);
    sysref_pin = 1'h0;
    #1 chk("sref_pin0", sref, 16'h0);
  endtask : t_sysref

  // Power-down request against both masks
  task automatic t_pdn();
    mpscfg_host_i.wr(MPSCFG_OFS_PDN, 8'hFF);
    chk("pdn_a", pdn_blocks, {4'h0, mask_a});
    rchk(MPSCFG_OFS_PDN, 8'h10);
    mpscfg_host_i.wr(MPSCFG_OFS_PDN_SEL, 8'h20);
    chk("pdn_b", pdn_blocks, {4'h0, mask_b});
    mpscfg_host_i.wr(MPSCFG_OFS_PDN, 8'h00);
    chk("pdn_off", pdn_blocks, 16'h0);
  endtask : t_pdn

  // Boost needs both bits; reserved bits read zero
  task automatic t_boost();
    for (int i = 0; i < 4; i++) begin
      mpscfg_host_i.wr(MPSCFG_OFS_BIAS_BOOST, {8{i[0]}});
      mpscfg_host_i.wr(MPSCFG_OFS_BIAS_EN, {8{i[1]}});
      chk("boost", boost, {15'h0, i == 3});
    end
    rchk(MPSCFG_OFS_BIAS_BOOST, 8'h40);
    rchk(MPSCFG_OFS_BIAS_EN, 8'h08);
  endtask : t_boost

  // Main sequence, with a second reset at the end
  initial begin
    t_reset();
    mpscfg_host_i.init();
    t_fixed();
    t_sysref();
    t_pdn();
    t_boost();
    t_reset();
    wrap_up();
  end

  // Watchdog at 3000 cycles, well past the expected 80 or so cycles
  initial begin
    #75000;
    error_cnt++;
    wrap_up();
  end
endmodule : mpscfg_regs_bench
